// [shared/dual_pwm_pkg.sv]
// constants, register map and mode codes for the dual pulse output block
package dual_pwm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PWM_PERIOD_NS  = 64000;
  localparam int unsigned PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_MS        = 100;
  localparam int unsigned TICK_CYC       = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [22:0] PERIOD_W       = 23'd6400;
  localparam logic [22:0] LEVEL_STEPS    = 23'h0003FF;
  localparam logic [22:0] STRENGTH_STEPS = 23'd445;

  // ---------------------------------------------------------------
  // strength mapping
  // ---------------------------------------------------------------
  localparam logic [16:0] STR_BASE_X100  = 17'd10680;
  localparam logic [16:0] STR_SLOPE_X100 = 17'd757;
  localparam logic [16:0] STR_DIV        = 17'd100;
  localparam logic [9:0]  STR_STEPS_0DB  = 10'd107;
  localparam logic [9:0]  STR_BELOW_DB   = 10'd4;
  localparam logic [9:0]  STR_BELOW_MAX  = 10'd102;
  localparam logic [8:0]  STR_STEPS_MIN  = 9'd5;
  localparam logic [8:0]  STR_STEPS_MAX  = 9'd445;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADR_CHAN0_LEVEL = 8'h00;
  localparam logic [7:0] ADR_CHAN1_LEVEL = 8'h04;
  localparam logic [7:0] ADR_TIMEOUT     = 8'h08;
  localparam logic [7:0] ADR_HOLD        = 8'h0C;
  localparam logic [7:0] ADR_CHAN0_MODE  = 8'h10;
  localparam logic [7:0] ADR_CHAN1_MODE  = 8'h14;
  localparam logic [7:0] ADR_CONTROL     = 8'h18;
  localparam logic [7:0] ADR_STATUS      = 8'h1C;
  localparam logic [7:0] ADR_BOUND_SRC   = 8'h20;
  localparam int unsigned CTRL_APPLY_BIT = 0;
  localparam int unsigned CTRL_EXIT_BIT  = 1;

  // ---------------------------------------------------------------
  // reset values and modes
  // ---------------------------------------------------------------
  localparam logic [9:0]  RST_LEVEL     = 10'h000;
  localparam logic [7:0]  RST_TIMEOUT   = 8'hFF;
  localparam logic [7:0]  RST_HOLD      = 8'h28;
  localparam logic [7:0]  HOLD_FOREVER  = 8'hFF;
  localparam logic [15:0] RST_BOUND_SRC = 16'hFFFF;
  localparam logic [15:0] BOUND_ANY     = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_OFF      = 2'b00,
    MODE_STRENGTH = 2'b01,
    MODE_LEVEL    = 2'b10,
    MODE_SPARE    = 2'b11
  } mode_t;

  localparam mode_t RST_MODE_A = MODE_STRENGTH;
  localparam mode_t RST_MODE_B = MODE_OFF;

endpackage

// [testbench/pwm_load_model.sv]
// behavioural load that integrates one pulse output over a fixed window
`timescale 1ns/1ns
`default_nettype none

module pwm_load_model #(
  parameter int unsigned WINDOW = 6400
) (
  input  wire logic        clk_i,
  input  wire logic        start_i,
  input  wire logic        pulse_i,
  output logic      [12:0] high_cnt_o,
  output logic             done_o
);
  int unsigned pos = WINDOW;

  // ---------------------------------------------------------------
  // count high cycles across one window
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    if (start_i) begin
      pos <= 0;
      high_cnt_o <= '0;
      done_o <= 1'b0;
    end else if (pos < WINDOW) begin
      pos <= pos + 1;
      high_cnt_o <= high_cnt_o + 13'(pulse_i);
      done_o <= (pos == WINDOW - 1);
    end
  end
endmodule

`default_nettype wire

// [testbench/test_dual_pwm_rssi_output.sv]
// self-checking bench for the dual pulse output block
`timescale 1ns/1ns
`default_nettype none

module test_dual_pwm_rssi_output;
  import dual_pwm_pkg::*;

  localparam int unsigned TICK = 400;

  typedef struct {logic [9:0] lvl_a; logic [9:0] lvl_b; logic [12:0] exp_a; logic [12:0] exp_b;} lvl_row_t;
  typedef struct {logic [7:0] margin; logic [12:0] exp_a;} str_row_t;

  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, sample_valid_i, rx_packet_i;
  logic [7:0]  wb_adr_i, rx_margin_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] sample_src_i;
  logic [9:0]  analog_sample_a_i, analog_sample_b_i;
  logic        pulse_out_a_o, pulse_out_b_o, start, done_a, done_b;
  logic [12:0] high_a, high_b;
  int          fail_count, num_checks;

  lvl_row_t    lvl_rows [3] = '{'{10'h1FF, 10'h3FF, 13'd3196, 13'd6400}, '{10'h001, 10'h000, 13'd6, 13'd0},
                                '{10'h3FF, 10'h1FF, 13'd6400, 13'd3196}};
  str_row_t    str_rows [6] = '{'{8'd10, 13'd2617}, '{8'd20, 13'd3710}, '{8'd30, 13'd4789},
                                '{8'h00, 13'd1538}, '{8'hFD, 13'd1366}, '{8'd60, 13'd6400}};
  logic [7:0]  rst_adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24};
  logic [31:0] rst_val [9] = '{32'h0, 32'h0, 32'hFF, 32'h28, 32'h1, 32'h0, 32'h0, 32'hFFFF, 32'h0};

  dual_pwm_rssi_output #(.TICK_CYCLES(TICK)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sample_valid_i(sample_valid_i), .sample_src_i(sample_src_i), .analog_sample_a_i(analog_sample_a_i),
    .analog_sample_b_i(analog_sample_b_i), .rx_packet_i(rx_packet_i), .rx_margin_i(rx_margin_i),
    .pulse_out_a_o(pulse_out_a_o), .pulse_out_b_o(pulse_out_b_o));
  pwm_load_model load_a (.clk_i(clk_i), .start_i(start), .pulse_i(pulse_out_a_o), .high_cnt_o(high_a), .done_o(done_a));
  pwm_load_model load_b (.clk_i(clk_i), .start_i(start), .pulse_i(pulse_out_b_o), .high_cnt_o(high_b), .done_o(done_b));

  // ---------------------------------------------------------------
  // bus, stimulus and compare tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic hung(input string what);
    fail_count++;
    $display("unexpected at %0t: no answer from %s", $time, what);
    results();
  endtask

  task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i <= we;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) hung("bus");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    num_checks++;
    if (rd !== exp) begin
      fail_count++;
      $display("unexpected at %0t: reg %h read %h want %h", $time, a, rd, exp);
    end
  endtask

  task automatic check_duty(input logic [12:0] exp_a, input logic [12:0] exp_b);
    int n;
    repeat (4) @(posedge clk_i);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (!(done_a === 1'b1 && done_b === 1'b1) && n < 7000);
    if (!(done_a === 1'b1 && done_b === 1'b1)) hung("load");
    num_checks++;
    if (high_a !== exp_a || high_b !== exp_b) begin
      fail_count++;
      $display("unexpected at %0t: high %0d/%0d want %0d/%0d", $time, high_a, high_b, exp_a, exp_b);
    end
  endtask

  task automatic send_sample(input logic [15:0] src, input logic [9:0] a, input logic [9:0] b);
    @(posedge clk_i);
    sample_valid_i <= 1'b1;
    sample_src_i <= src;
    analog_sample_a_i <= a;
    analog_sample_b_i <= b;
    @(posedge clk_i);
    sample_valid_i <= 1'b0;
  endtask

  task automatic send_packet(input logic [7:0] m);
    @(posedge clk_i);
    rx_packet_i <= 1'b1;
    rx_margin_i <= m;
    @(posedge clk_i);
    rx_packet_i <= 1'b0;
  endtask

  // ---------------------------------------------------------------
  // clock and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, sample_valid_i, rx_packet_i, start} = 7'h40;
    {wb_adr_i, rx_margin_i, wb_dat_i, sample_src_i, analog_sample_a_i, analog_sample_b_i} = '0;
    wb_sel_i = 4'hF;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (lvl_rows[i]) begin
      wb(ADR_CHAN0_LEVEL, 1'b1, 32'(lvl_rows[i].lvl_a));
      wb(ADR_CHAN1_LEVEL, 1'b1, 32'(lvl_rows[i].lvl_b));
      wb(ADR_CHAN0_MODE, 1'b1, 32'(MODE_LEVEL));
      wb(ADR_CHAN1_MODE, 1'b1, 32'(MODE_LEVEL));
      wb(ADR_CONTROL, 1'b1, 32'h1);
      check_reg(ADR_CHAN0_LEVEL, 32'(lvl_rows[i].lvl_a));
      check_duty(lvl_rows[i].exp_a, lvl_rows[i].exp_b);
    end
    wb(ADR_CHAN0_LEVEL, 1'b1, 32'h100);
    check_reg(ADR_STATUS, 32'h01FF_03FF);
    wb(ADR_CONTROL, 1'b1, 32'h2);
    check_reg(ADR_STATUS, 32'h01FF_0100);
    wb(ADR_BOUND_SRC, 1'b1, 32'h1234);
    wb(ADR_TIMEOUT, 1'b1, 32'h6);
    wb(ADR_CONTROL, 1'b1, 32'h1);
    send_sample(16'h0001, 10'h2AA, 10'h155);
    check_reg(ADR_STATUS, 32'h01FF_0100);
    repeat (5) begin
      send_sample(16'h1234, 10'h2AA, 10'h155);
      repeat (1000) @(posedge clk_i);
    end
    check_reg(ADR_STATUS, 32'h0155_02AA);
    repeat (3500) @(posedge clk_i);
    check_reg(ADR_STATUS, 32'h0);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h24, 1'b1, 32'hFFFF_FFFF);
    wb(ADR_STATUS, 1'b1, 32'hFFFF_FFFF);
    foreach (rst_adr[i]) check_reg(rst_adr[i], rst_val[i]);
    wb_sel_i <= 4'h2;
    wb(ADR_CHAN0_LEVEL, 1'b1, 32'h0000_01AB);
    wb_sel_i <= 4'hF;
    check_reg(ADR_CHAN0_LEVEL, 32'h0000_0100);
    wb(ADR_CHAN0_LEVEL, 1'b1, 32'h0);
    check_duty(13'd0, 13'd0);
    foreach (str_rows[i]) begin
      send_packet(str_rows[i].margin);
      check_duty(str_rows[i].exp_a, 13'd0);
    end
    wb(ADR_HOLD, 1'b1, 32'h2);
    wb(ADR_CONTROL, 1'b1, 32'h1);
    send_packet(8'd10);
    check_reg(ADR_STATUS, 32'h8000_0000);
    repeat (1500) @(posedge clk_i);
    check_reg(ADR_STATUS, 32'h0);
    wb(ADR_HOLD, 1'b1, 32'h0);
    wb(ADR_CONTROL, 1'b1, 32'h1);
    send_packet(8'd20);
    check_reg(ADR_STATUS, 32'h0);
    wb(ADR_HOLD, 1'b1, 32'hFF);
    wb(ADR_CONTROL, 1'b1, 32'h1);
    send_packet(8'd30);
    check_duty(13'd4789, 13'd0);
    results();
  end
endmodule

`default_nettype wire

// [verilog/dual_pwm_rssi_output.sv]
// dual pulse-width output with strength display, timeouts and wishbone registers
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none

module dual_pwm_rssi_output #(
  parameter int unsigned TICK_CYCLES = dual_pwm_pkg::TICK_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] sample_src_i,
  input  wire logic [9:0]  analog_sample_a_i,
  input  wire logic [9:0]  analog_sample_b_i,
  input  wire logic        rx_packet_i,
  input  wire logic [7:0]  rx_margin_i,
  output logic             pulse_out_a_o,
  output logic             pulse_out_b_o
);
  import dual_pwm_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [31:0] dat, input logic [3:0] sel);
    wr_byte = sel[0] ? dat[7:0] : old;
  endfunction

  function automatic logic [9:0] wr_level(input logic [9:0] old, input logic [31:0] dat, input logic [3:0] sel);
    wr_level = {(sel[1] ? dat[9:8] : old[9:8]), (sel[0] ? dat[7:0] : old[7:0])};
  endfunction

  function automatic logic [12:0] high_cycles(input logic [9:0] val, input logic [22:0] steps);
    logic [22:0] prod;
    prod = 23'(val) * PERIOD_W;
    high_cycles = 13'(prod / steps);
  endfunction

  function automatic logic [8:0] margin_steps(input logic [7:0] m);
    logic [7:0]  neg;
    logic [9:0]  below;
    logic [16:0] v;
    neg = 8'(~m + 8'h01);
    below = 10'(neg) * STR_BELOW_DB;
    v = 17'(STR_BASE_X100 + 17'(m[6:0]) * STR_SLOPE_X100) / STR_DIV;
    if (m[7] || m == 8'h00) begin
      margin_steps = (below >= STR_BELOW_MAX) ? STR_STEPS_MIN : 9'(STR_STEPS_0DB - below);
    end else begin
      margin_steps = (v > 17'(STR_STEPS_MAX)) ? STR_STEPS_MAX : v[8:0];
    end
  endfunction

  // ---------------------------------------------------------------
  // bus and queued settings
  // ---------------------------------------------------------------
  logic [9:0]  lvl_a_p_q, lvl_a_p_d, lvl_b_p_q, lvl_b_p_d;
  logic [7:0]  timeout_p_q, timeout_p_d, hold_p_q, hold_p_d;
  logic [1:0]  mode_a_p_q, mode_a_p_d, mode_b_p_q, mode_b_p_d;
  logic [15:0] bound_q, bound_d;
  logic        ack_q, ack_d, apply_q, apply_d;
  logic [31:0] rdata_q, rdata_d;

  // active state
  logic [9:0]  lvl_a_q, lvl_a_d, lvl_b_q, lvl_b_d;
  logic [7:0]  timeout_q, timeout_d, hold_q, hold_d;
  mode_t       mode_a_q, mode_a_d, mode_b_q, mode_b_d;
  logic [7:0]  to_cnt_q, to_cnt_d, hold_cnt_q, hold_cnt_d;
  logic        to_run_q, to_run_d, str_on_q, str_on_d;
  logic [8:0]  str_steps_q, str_steps_d;
  logic [23:0] tick_cnt_q, tick_cnt_d;
  logic        tick, sample_hit;

  // output stage
  logic [12:0] pwm_cnt_q, pwm_cnt_d, thr_a, thr_b;
  logic        out_a_q, out_a_d, out_b_q, out_b_d;

  always_comb begin
    lvl_a_p_d = lvl_a_p_q;
    lvl_b_p_d = lvl_b_p_q;
    timeout_p_d = timeout_p_q;
    hold_p_d = hold_p_q;
    mode_a_p_d = mode_a_p_q;
    mode_b_p_d = mode_b_p_q;
    bound_d = bound_q;
    apply_d = 1'b0;
    rdata_d = rdata_q;
    ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
    if (ack_d) begin
      rdata_d = 32'h0000_0000;
      if (wb_adr_i == ADR_CHAN0_LEVEL) begin
        rdata_d = {22'h00_0000, lvl_a_p_q};
        if (wb_we_i) lvl_a_p_d = wr_level(lvl_a_p_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_CHAN1_LEVEL) begin
        rdata_d = {22'h00_0000, lvl_b_p_q};
        if (wb_we_i) lvl_b_p_d = wr_level(lvl_b_p_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_TIMEOUT) begin
        rdata_d = {24'h00_0000, timeout_p_q};
        if (wb_we_i) timeout_p_d = wr_byte(timeout_p_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_HOLD) begin
        rdata_d = {24'h00_0000, hold_p_q};
        if (wb_we_i) hold_p_d = wr_byte(hold_p_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == ADR_CHAN0_MODE) begin
        rdata_d = {30'h0000_0000, mode_a_p_q};
        if (wb_we_i && wb_sel_i[0]) mode_a_p_d = wb_dat_i[1:0];
      end else if (wb_adr_i == ADR_CHAN1_MODE) begin
        rdata_d = {30'h0000_0000, mode_b_p_q};
        if (wb_we_i && wb_sel_i[0]) mode_b_p_d = wb_dat_i[1:0];
      end else if (wb_adr_i == ADR_CONTROL) begin
        apply_d = wb_we_i & wb_sel_i[0] & (wb_dat_i[CTRL_APPLY_BIT] | wb_dat_i[CTRL_EXIT_BIT]);
      end else if (wb_adr_i == ADR_STATUS) begin
        rdata_d = {str_on_q, 5'h00, lvl_b_q, 6'h00, lvl_a_q};
      end else if (wb_adr_i == ADR_BOUND_SRC) begin
        rdata_d = {16'h0000, bound_q};
        if (wb_we_i) bound_d = {wr_byte(bound_q[15:8], {24'h00_0000, wb_dat_i[15:8]}, {3'h0, wb_sel_i[1]}),
                                wr_byte(bound_q[7:0], wb_dat_i, wb_sel_i)};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_a_p_q <= RST_LEVEL;
      lvl_b_p_q <= RST_LEVEL;
      timeout_p_q <= RST_TIMEOUT;
      hold_p_q <= RST_HOLD;
      mode_a_p_q <= RST_MODE_A;
      mode_b_p_q <= RST_MODE_B;
      bound_q <= RST_BOUND_SRC;
      ack_q <= 1'b0;
      apply_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      lvl_a_p_q <= lvl_a_p_d;
      lvl_b_p_q <= lvl_b_p_d;
      timeout_p_q <= timeout_p_d;
      hold_p_q <= hold_p_d;
      mode_a_p_q <= mode_a_p_d;
      mode_b_p_q <= mode_b_p_d;
      bound_q <= bound_d;
      ack_q <= ack_d;
      apply_q <= apply_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // active settings, timers and samples
  // ---------------------------------------------------------------
  always_comb begin
    lvl_a_d = lvl_a_q;
    lvl_b_d = lvl_b_q;
    timeout_d = timeout_q;
    hold_d = hold_q;
    mode_a_d = mode_a_q;
    mode_b_d = mode_b_q;
    to_cnt_d = to_cnt_q;
    to_run_d = to_run_q;
    hold_cnt_d = hold_cnt_q;
    str_on_d = str_on_q;
    str_steps_d = str_steps_q;
    tick = (tick_cnt_q == 24'(TICK_CYCLES - 1));
    tick_cnt_d = tick ? 24'h00_0000 : 24'(tick_cnt_q + 24'h00_0001);
    sample_hit = sample_valid_i & ((bound_q == BOUND_ANY) | (bound_q == sample_src_i));
    if (apply_q) begin
      lvl_a_d = lvl_a_p_q;
      lvl_b_d = lvl_b_p_q;
      timeout_d = timeout_p_q;
      hold_d = hold_p_q;
      mode_a_d = mode_t'(mode_a_p_q);
      mode_b_d = (mode_b_p_q == MODE_LEVEL) ? MODE_LEVEL : MODE_OFF;
    end
    if (to_run_q && tick && timeout_q != 8'h00) begin
      if (9'(to_cnt_q) + 9'h001 >= 9'(timeout_q)) begin
        lvl_a_d = 10'h000;
        lvl_b_d = 10'h000;
        to_run_d = 1'b0;
        to_cnt_d = 8'h00;
      end else begin
        to_cnt_d = 8'(to_cnt_q + 8'h01);
      end
    end
    if (sample_hit) begin
      to_cnt_d = 8'h00;
      if (mode_a_q == MODE_LEVEL) lvl_a_d = analog_sample_a_i;
      if (mode_b_q == MODE_LEVEL) lvl_b_d = analog_sample_b_i;
      to_run_d = (lvl_a_d != 10'h000) | (lvl_b_d != 10'h000);
    end
    if (rx_packet_i) begin
      str_steps_d = margin_steps(rx_margin_i);
      hold_cnt_d = 8'h00;
      str_on_d = 1'b1;
    end else if (str_on_q && tick && hold_q != HOLD_FOREVER) begin
      if (9'(hold_cnt_q) + 9'h001 >= 9'(hold_q)) begin
        str_on_d = 1'b0;
      end else begin
        hold_cnt_d = 8'(hold_cnt_q + 8'h01);
      end
    end
    if (hold_q == 8'h00) str_on_d = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_a_q <= RST_LEVEL;
      lvl_b_q <= RST_LEVEL;
      timeout_q <= RST_TIMEOUT;
      hold_q <= RST_HOLD;
      mode_a_q <= RST_MODE_A;
      mode_b_q <= RST_MODE_B;
      to_cnt_q <= 8'h00;
      to_run_q <= 1'b0;
      hold_cnt_q <= 8'h00;
      str_on_q <= 1'b0;
      str_steps_q <= 9'h000;
      tick_cnt_q <= 24'h00_0000;
    end else begin
      lvl_a_q <= lvl_a_d;
      lvl_b_q <= lvl_b_d;
      timeout_q <= timeout_d;
      hold_q <= hold_d;
      mode_a_q <= mode_a_d;
      mode_b_q <= mode_b_d;
      to_cnt_q <= to_cnt_d;
      to_run_q <= to_run_d;
      hold_cnt_q <= hold_cnt_d;
      str_on_q <= str_on_d;
      str_steps_q <= str_steps_d;
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // pulse generation
  // ---------------------------------------------------------------
  always_comb begin
    pwm_cnt_d = (pwm_cnt_q == 13'(PWM_PERIOD_CYC - 1)) ? 13'h0000 : 13'(pwm_cnt_q + 13'h0001);
    thr_a = 13'h0000;
    thr_b = 13'h0000;
    case (mode_a_q)
      MODE_LEVEL:    thr_a = high_cycles(lvl_a_q, LEVEL_STEPS);
      MODE_STRENGTH: thr_a = str_on_q ? high_cycles({1'b0, str_steps_q}, STRENGTH_STEPS) : 13'h0000;
      default:       thr_a = 13'h0000;
    endcase
    if (mode_b_q == MODE_LEVEL) thr_b = high_cycles(lvl_b_q, LEVEL_STEPS);
    out_a_d = (pwm_cnt_q < thr_a);
    out_b_d = (pwm_cnt_q < thr_b);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_cnt_q <= 13'h0000;
      out_a_q <= 1'b0;
      out_b_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      out_a_q <= out_a_d;
      out_b_q <= out_b_d;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign pulse_out_a_o = out_a_q;
  assign pulse_out_b_o = out_b_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_period_wrap: assert property (pwm_cnt_q == 13'(PWM_PERIOD_CYC - 1) |=> pwm_cnt_q == 13'h0000)
    else $error("pwm period not 6400 cycles");
  chk_level_zero_low: assert property (mode_b_q == MODE_LEVEL && lvl_b_q == 10'h000 |=> !pulse_out_b_o)
    else $error("zero level gave high output");
  chk_level_full_high: assert property (mode_a_q == MODE_LEVEL && lvl_a_q == 10'h3FF |=> pulse_out_a_o)
    else $error("full level gave low output");
  chk_apply_copies: assert property (apply_q && !sample_hit && !to_run_q |=> lvl_a_q == $past(lvl_a_p_q))
    else $error("apply did not load level");
  chk_reset_defaults: assert property ($past(rst_i) |-> timeout_q == RST_TIMEOUT && hold_q == RST_HOLD)
    else $error("timer settings wrong after reset");
  chk_sample_restart: assert property (sample_hit |=> to_cnt_q == 8'h00)
    else $error("sample did not restart timer");
  chk_sample_level: assert property (sample_hit && mode_a_q == MODE_LEVEL |=> lvl_a_q == $past(analog_sample_a_i))
    else $error("sample did not replace level");
  chk_hold_zero_off: assert property (hold_q == 8'h00 |=> !str_on_q)
    else $error("strength active with zero hold");
  chk_hold_forever: assert property (hold_q == 8'hFF && str_on_q |=> str_on_q)
    else $error("strength dropped with hold 0xFF");
  chk_strength_idle: assert property (mode_a_q == MODE_STRENGTH && !str_on_q |=> !pulse_out_a_o)
    else $error("inactive strength output high");
  chk_timeout_zero: assert property (to_run_q && tick && timeout_q != 8'h00 && {1'b0, to_cnt_q} + 9'h001 >= {1'b0, timeout_q}
                                     && !sample_hit |=> lvl_a_q == 10'h000 && lvl_b_q == 10'h000)
    else $error("timeout expiry did not clear level");

endmodule

`default_nettype wire
